// >>> core/sbp_pkg.sv
// Package for the pipelined burst SRAM port
package sbp_pkg;
  localparam int SBP_LANES = 4;
  localparam int SBP_LANE_W = 9;
  localparam int SBP_ADDR_W = 10;
  localparam int SBP_BURST_W = 2;
  localparam logic [1:0] SBP_CNT_RST = 2'h0;
  localparam logic [1:0] SBP_CNT_STEP = 2'h1;
  localparam int SBP_READ_LAT = 2;
  typedef enum logic [1:0] {SBP_IDLE, SBP_READ, SBP_WRITE} sbp_op_e;
endpackage : sbp_pkg

// >>> core/sbp_port.sv
// Pipelined burst SRAM port with internal array
`timescale 1ns/10ps
// Notes on behaviour
// RULE_01 - All synchronous inputs are captured on the rising clock edge only.
// RULE_02 - A 2-bit counter supplies the low address bits during bursts.
// RULE_03 - Output enable acts without the clock; burst order is registered over two clock edges.
// RULE_04 - Address and select load only on a load strobe.
// RULE_05 - Low step input advances the counter; high holds the address.
// RULE_06 - Writes complete internally after one registered edge.
// RULE_07 - Each lane enable writes its eight data bits and parity bit.
// RULE_08 - Lane enables act only while the byte-write gate is low.
// RULE_09 - Low global write writes every lane regardless of other enables.
// RULE_10 - Written data is forwarded to an immediately following read.
// RULE_11 - Deselection takes effect over two pipelined cycles.
// RULE_12 - Selected needs both low selects low and high select high.
// RULE_13 - Processor load with first select low starts a read burst.
// RULE_14 - Controller load selects or deselects and starts read or write.
// RULE_15 - Burst order input low is linear, high is interleaved.
// RULE_16 - Interleaved addresses are start XOR 00, 01, 10, 11.
// RULE_17 - High sleep request puts the device in standby.
// RULE_18 - Any enabled lane low means write; all high means read.
// RULE_19 - Data pins release while a gated lane enable is low.
// RULE_20 - Burst delivers first word after three clocks, then one per clock.
// RULE_21 - Narrow variant uses two lanes and one extra address bit.
// RULE_22 - Parity bits are stored and returned, never computed.
// RULE_23 - Processor load starts a read; the next cycle may write.
// RULE_24 - Linear order counts the low bits upward, wrapping in four.
// RULE_25 - A wait cycle reuses the current address.
// RULE_26 - Burst counter never carries into the upper address bits.
module sbp_port
  import sbp_pkg::*;
#(
  parameter int LANES = SBP_LANES, // see RULE_21
  parameter int ADDR_W = SBP_ADDR_W
)
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic chip_select_n_i,
  input wire logic chip_select_low_n_i,
  input wire logic chip_select_high_i,
  input wire logic processor_load_n_i,
  input wire logic controller_load_n_i,
  input wire logic burst_step_n_i,
  input wire logic byte_write_gate_n_i,
  input wire logic global_write_n_i,
  input wire logic [LANES-1:0] lane_write_n_i,
  input wire logic output_drive_n_i,
  input wire logic burst_order_i,
  input wire logic sleep_request_i,
  input wire logic [LANES*8-1:0] data_i,
  input wire logic [LANES-1:0] lane_parity_i,
  output logic [LANES*8-1:0] data_o,
  output logic [LANES-1:0] lane_parity_o,
  output logic data_oe_n_o,
  output logic q_valid_o,
  input wire logic q_ready_i,
  output logic standby_o
);

  // ****************************************
  // Input capture
  // ****************************************
  localparam int W = LANES * SBP_LANE_W;
  logic [ADDR_W-1:0] addr_q;
  logic cs_n_q;
  logic csl_n_q;
  logic csh_q;
  logic pl_n_q;
  logic cl_n_q;
  logic step_n_q;
  logic bwg_n_q;
  logic gw_n_q;
  logic [LANES-1:0] bw_n_q;
  logic [W-1:0] din_q;
  wire [W-1:0] din_next;
  logic [1:0] mode_s;
  logic [1:0] sleep_s;

  always_ff @(posedge clk_i)
  begin
    addr_q <= addr_i; // see RULE_01
    cs_n_q <= chip_select_n_i;
    csl_n_q <= chip_select_low_n_i;
    csh_q <= chip_select_high_i;
    pl_n_q <= processor_load_n_i;
    cl_n_q <= controller_load_n_i;
    step_n_q <= burst_step_n_i;
    bwg_n_q <= byte_write_gate_n_i;
    gw_n_q <= global_write_n_i;
    bw_n_q <= lane_write_n_i;
    din_q <= din_next;
    mode_s <= {mode_s[0], burst_order_i}; // see RULE_15
    sleep_s <= {sleep_s[0], sleep_request_i}; // see RULE_17
  end

  // Lane packing: eight data bits then parity per lane
  genvar g;
  for (g = 0; g < LANES; g++)
  begin : g_pack
    assign din_next[g*SBP_LANE_W +: SBP_LANE_W] =
      {lane_parity_i[g], data_i[g*8 +: 8]}; // see RULE_22
  end

  // ****************************************
  // Decode
  // ****************************************
  logic selected;
  logic pl_take;
  logic cl_take;
  logic load;
  logic [LANES-1:0] lane_we;
  logic any_write;

  assign selected = !cs_n_q && !csl_n_q && csh_q; // see RULE_12
  assign pl_take = !pl_n_q && !cs_n_q; // see RULE_13
  assign cl_take = !cl_n_q && !pl_take;
  assign load = pl_take || cl_take; // see RULE_04
  always_comb
  begin
    for (int i = 0; i < LANES; i++)
    begin
      lane_we[i] = !gw_n_q || (!bwg_n_q && !bw_n_q[i]); // see RULE_08
    end
  end
  assign any_write = |lane_we; // see RULE_09 see RULE_18

  // ****************************************
  // Address and burst counter
  // ****************************************
  logic [ADDR_W-1:0] base;
  logic [1:0] cnt;
  logic active;
  logic [1:0] low_bits;
  logic [ADDR_W-1:0] cur_addr;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      base <= '0;
      cnt <= SBP_CNT_RST;
    end
    else if (load && (pl_take || selected))
    begin
      base <= addr_q; // see RULE_04
      cnt <= SBP_CNT_RST;
    end
    else if (active && !step_n_q)
    begin
      cnt <= cnt + SBP_CNT_STEP; // see RULE_05 see RULE_26
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      active <= 1'b0;
    end
    else if (load)
    begin
      active <= selected; // see RULE_14
    end
  end

  // Interleave XORs, linear adds within the group
  assign low_bits = mode_s[1] ? (base[1:0] ^ cnt) :
                    2'(base[1:0] + cnt); // see RULE_16 see RULE_24
  assign cur_addr = {base[ADDR_W-1:2], low_bits}; // see RULE_02 see RULE_25

  // ****************************************
  // Operation and array
  // ****************************************
  sbp_op_e op;
  logic [W-1:0] mem [2**ADDR_W];
  logic [W-1:0] rd_word;
  logic [ADDR_W-1:0] wr_addr;
  logic [W-1:0] wr_data;
  logic [LANES-1:0] wr_en;
  logic [W-1:0] mem_rd;
  wire [W-1:0] wr_word;

  always_comb
  begin
    if (!active || sleep_s[1])
    begin
      op = SBP_IDLE; // see RULE_17
    end
    else if (load && pl_take)
    begin
      op = SBP_READ; // see RULE_23
    end
    else if (any_write)
    begin
      op = SBP_WRITE; // see RULE_06
    end
    else
    begin
      op = SBP_READ;
    end
  end

  assign mem_rd = mem[cur_addr];

  for (g = 0; g < LANES; g++)
  begin : g_wr
    assign wr_word[g*SBP_LANE_W +: SBP_LANE_W] = lane_we[g] ?
      din_q[g*SBP_LANE_W +: SBP_LANE_W] :
      mem_rd[g*SBP_LANE_W +: SBP_LANE_W]; // see RULE_07
  end

  always_ff @(posedge clk_i)
  begin
    if (op == SBP_WRITE)
    begin
      mem[cur_addr] <= wr_word; // see RULE_06
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      wr_en <= '0;
    end
    else
    begin
      wr_en <= (op == SBP_WRITE) ? lane_we : '0;
    end
    wr_addr <= cur_addr;
    wr_data <= din_q;
  end

  // Pass-through of the last written lanes
  always_comb
  begin
    rd_word = mem[cur_addr];
    for (int i = 0; i < LANES; i++)
    begin
      if (wr_en[i] && wr_addr == cur_addr)
      begin
        rd_word[i*SBP_LANE_W +: SBP_LANE_W] =
          wr_data[i*SBP_LANE_W +: SBP_LANE_W]; // see RULE_10
      end
    end
  end

  // ****************************************
  // Output pipeline and two-entry buffer
  // ****************************************
  logic [SBP_READ_LAT-1:0] sel_pipe;
  logic rd_v;
  logic [W-1:0] rd_q;
  logic [W-1:0] buf_d [2];
  logic [1:0] buf_cnt;
  logic buf_wp;
  logic buf_rp;
  logic push;
  logic pop;
  logic next_rp;
  logic [W-1:0] next_head;
  wire [LANES*8-1:0] next_q;
  wire [LANES-1:0] next_par;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      sel_pipe <= '0;
      rd_v <= 1'b0;
    end
    else
    begin
      sel_pipe <= {sel_pipe[0], active}; // see RULE_11
      rd_v <= (op == SBP_READ) && buf_cnt != 2'h2; // see RULE_20
    end
    rd_q <= rd_word;
  end

  assign push = rd_v && (buf_cnt != 2'h2 || pop); // see RULE_20
  assign pop = q_valid_o && q_ready_i;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      buf_cnt <= 2'h0;
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        buf_d[buf_wp] <= rd_q;
        buf_wp <= !buf_wp;
      end
      if (pop)
      begin
        buf_rp <= !buf_rp;
      end
      buf_cnt <= 2'(buf_cnt + {1'b0, push} - {1'b0, pop});
    end
  end

  assign q_valid_o = buf_cnt != 2'h0;

  // Head after this edge, so data_o matches q_valid_o
  always_comb
  begin
    next_rp = pop ? !buf_rp : buf_rp;
    next_head = buf_d[next_rp];
    if (push && buf_wp == next_rp)
    begin
      next_head = rd_q;
    end
  end

  for (g = 0; g < LANES; g++)
  begin : g_out
    assign next_q[g*8 +: 8] = next_head[g*SBP_LANE_W +: 8];
    assign next_par[g] = next_head[g*SBP_LANE_W + 8]; // see RULE_22
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      data_o <= '0;
      lane_parity_o <= '0;
    end
    else
    begin
      data_o <= next_q;
      lane_parity_o <= next_par;
    end
  end

  // Drive is gated asynchronously by the output enable
  assign data_oe_n_o = output_drive_n_i || sel_pipe[1] == 1'b0 ||
                       (!byte_write_gate_n_i && !(&lane_write_n_i)) ||
                       !global_write_n_i; // see RULE_03 see RULE_19
  assign standby_o = sleep_s[1];

endmodule : sbp_port

// >>> test/sbp_port_asserts.sv
// Checker for the burst SRAM port
`timescale 1ns/10ps
// ************************************
// Port checker
// ************************************
module sbp_port_chk
  import sbp_pkg::*;
#(
  parameter int LANES = SBP_LANES
)
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic processor_load_n_i,
  input wire logic chip_select_n_i,
  input wire logic byte_write_gate_n_i,
  input wire logic [LANES-1:0] lane_write_n_i,
  input wire logic output_drive_n_i,
  input wire logic sleep_request_i,
  input wire logic [LANES*8-1:0] data_o,
  input wire logic data_oe_n_o,
  input wire logic q_valid_o,
  input wire logic q_ready_i,
  input wire logic standby_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  property p_oe_off; output_drive_n_i |-> data_oe_n_o; endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe driven");
  property p_hiz;
    (!byte_write_gate_n_i && !(&lane_write_n_i))[*2] |-> data_oe_n_o;
  endproperty
  a_hiz: assert property (p_hiz) else $error("pins driven");
  property p_sleep; sleep_request_i[*5] |-> standby_o; endproperty
  a_sleep: assert property (p_sleep) else $error("no standby");
  property p_wake; !sleep_request_i[*5] |-> !standby_o; endproperty
  a_wake: assert property (p_wake) else $error("stuck standby");
  property p_hold; q_valid_o && !q_ready_i |=> q_valid_o; endproperty
  a_hold: assert property (p_hold) else $error("word lost");
  property p_keep;
    q_valid_o && !q_ready_i ##1 !q_ready_i |=> $stable(data_o);
  endproperty
  a_keep: assert property (p_keep) else $error("word moved");
  property p_rst; disable iff (1'h0) srst_i |=> !q_valid_o; endproperty
  a_rst: assert property (p_rst) else $error("valid in reset");
  property p_ans;
    !processor_load_n_i && !chip_select_n_i && !sleep_request_i && !standby_o
      |-> ##[1:6] q_valid_o;
  endproperty
  a_ans: assert property (p_ans) else $error("no read word");
  c_burst: cover property ((q_valid_o && q_ready_i)[*4]);
  c_stall: cover property (q_valid_o && !q_ready_i);
  c_sleep: cover property ($rose(standby_o));
endmodule : sbp_port_chk
bind sbp_port sbp_port_chk #(.LANES(LANES)) u_chk (.clk_i, .srst_i,
  .processor_load_n_i, .chip_select_n_i, .byte_write_gate_n_i,
  .lane_write_n_i, .output_drive_n_i, .sleep_request_i, .data_o,
  .data_oe_n_o, .q_valid_o, .q_ready_i, .standby_o);

// >>> test/sbp_sink.sv
// Receiver model for the read word stream
`timescale 1ns/10ps
// ************************************
// Word receiver
// ************************************
module sbp_sink
(
  input wire logic clk_i,
  input wire logic stall_i,
  input wire logic valid_i,
  input wire logic [35:0] word_i,
  output logic ready_o
);
  logic [35:0] got [$];
  assign ready_o = !stall_i;
  always @(posedge clk_i)
    if (valid_i && ready_o)
    begin
      got.push_back(word_i);
    end
endmodule : sbp_sink

// >>> test/sbp_port_tb.sv
// Self-checking bench for the burst port
`timescale 1ns/10ps
// ************************************
// Stimulus and checks
// ************************************
module sbp_port_tb;
  import sbp_pkg::*;
  logic clk_i = 1'h0, srst_i = 1'h1, stall = 1'h0, burst_order_i = 1'h0;
  logic chip_select_n_i = 1'h1, processor_load_n_i = 1'h1;
  logic controller_load_n_i = 1'h1, burst_step_n_i = 1'h1;
  logic byte_write_gate_n_i = 1'h1, global_write_n_i = 1'h1;
  logic output_drive_n_i = 1'h0, sleep_request_i = 1'h0, q_ready_i;
  logic [9:0] addr_i = '0;
  logic [3:0] lane_write_n_i = 4'hf, lane_parity_i = '0, lane_parity_o;
  logic [31:0] data_i = '0, data_o;
  logic data_oe_n_o, q_valid_o, standby_o;
  logic [35:0] mem [4];
  int err_total = 0, num_checks = 0;
  always #20 clk_i = ~clk_i;
  sbp_port DUT (.clk_i, .srst_i, .addr_i, .chip_select_n_i,
    .chip_select_low_n_i(1'h0), .chip_select_high_i(1'h1),
    .processor_load_n_i, .controller_load_n_i, .burst_step_n_i,
    .byte_write_gate_n_i, .global_write_n_i, .lane_write_n_i,
    .output_drive_n_i, .burst_order_i, .sleep_request_i, .data_i,
    .lane_parity_i, .data_o, .lane_parity_o, .data_oe_n_o, .q_valid_o,
    .q_ready_i, .standby_o);
  sbp_sink u_sink (.clk_i, .stall_i(stall), .valid_i(q_valid_o),
    .word_i({lane_parity_o, data_o}), .ready_o(q_ready_i));
  task automatic chk(string n, logic [35:0] e, logic [35:0] s);
    num_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask : chk
  task automatic desel;
    @(negedge clk_i);
    controller_load_n_i = 1'h0;
    chip_select_n_i = 1'h1;
    processor_load_n_i = 1'h1;
    burst_step_n_i = 1'h1;
    global_write_n_i = 1'h1;
    lane_write_n_i = 4'hf;
    @(negedge clk_i);
    controller_load_n_i = 1'h1;
    repeat (8) @(negedge clk_i);
  endtask : desel
  task automatic wr(logic [1:0] a, logic [35:0] w, logic [3:0] ln, logic g, gw);
    u_sink.got.delete();
    @(negedge clk_i);
    addr_i = {8'h00, a};
    {lane_parity_i, data_i} = w;
    chip_select_n_i = 1'h0;
    controller_load_n_i = 1'h0;
    lane_write_n_i = ln;
    byte_write_gate_n_i = g;
    global_write_n_i = gw;
    @(negedge clk_i);
    controller_load_n_i = 1'h1;
    @(negedge clk_i);
    global_write_n_i = 1'h1;
    lane_write_n_i = 4'hf;
    desel();
    chk("pass", mem[a], u_sink.got[0]);
  endtask : wr
  task automatic rd(logic [1:0] a, logic o, logic [7:0] s, int n);
    burst_order_i = o;
    repeat (4) @(negedge clk_i);
    u_sink.got.delete();
    addr_i = {8'h00, a};
    chip_select_n_i = 1'h0;
    processor_load_n_i = 1'h0;
    for (int i = 1; i < n; i++)
    begin
      @(negedge clk_i);
      processor_load_n_i = 1'h1;
      burst_step_n_i = 1'h0;
    end
    desel();
    for (int i = 0; i < n && !stall; i++)
      chk("burst", mem[s[7-2*i -: 2]], u_sink.got[i]);
  endtask : rd
  task automatic t_stall;
    stall = 1'h1;
    rd(2'h3, 1'h0, 8'hc6, 4);
    chk("held", 36'h0, 36'(u_sink.got.size()));
    stall = 1'h0;
    repeat (4) @(negedge clk_i);
    chk("kept", 36'h2, 36'(u_sink.got.size()));
    chk("head", mem[3], u_sink.got[0]);
    chk("next", mem[0], u_sink.got[1]);
  endtask : t_stall
  task automatic t_sleep;
    sleep_request_i = 1'h1;
    output_drive_n_i = 1'h1;
    repeat (6) @(negedge clk_i);
    chk("standby", 36'h1, standby_o);
    chk("oe", 36'h1, data_oe_n_o);
    sleep_request_i = 1'h0;
    output_drive_n_i = 1'h0;
    repeat (6) @(negedge clk_i);
    chk("wake", 36'h0, standby_o);
  endtask : t_sleep
  task automatic wrap_up;
    $display("Checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (10) @(negedge clk_i);
    srst_i = 1'h0;
    for (int a = 0; a < 4; a++)
    begin
      mem[a] = {9{a[3:0] + 4'h1}};
      wr(a[1:0], mem[a], 4'hf, 1'h1, 1'h0);
    end
    rd(2'h1, 1'h1, 8'h4e, 4);
    rd(2'h2, 1'h0, 8'hb1, 4);
    mem[0][7:0] = 8'hff;
    mem[0][32] = 1'h1;
    wr(2'h0, '1, 4'he, 1'h0, 1'h1);
    wr(2'h1, '1, 4'he, 1'h1, 1'h1);
    rd(2'h0, 1'h0, 8'h1b, 2);
    t_stall();
    t_sleep();
    wrap_up();
  end
  initial
  begin
    #200000;
    err_total++;
    wrap_up();
  end
endmodule : sbp_port_tb
